/* core/cas_fan_alarms.sv */
// per-fan alarms from polling timeouts and fan status words
`timescale 1ns/1ps
`include "cas_regs.svh"
module cas_fan_alarms
  import cas_pkg::*;
#(
  parameter int NUM_FANS = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] fan_count_i,
  input wire logic [NUM_FANS-1:0] fan_timeout_i,
  input wire logic [NUM_FANS-1:0][15:0] fan_status_i,
  output cas_fan_flags_t [NUM_FANS-1:0] flags_o
);
  cas_fan_flags_t [NUM_FANS-1:0] flags_reg;
  genvar i;
  generate
    for (i = 0; i < NUM_FANS; i++)
    begin : g_fan
      logic served;
      // fan i is fan number i+1
      assign served = cas_fan_in_range(i + 1, fan_count_i);
      // out-of-range fans drop every alarm at once
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          flags_reg[i] <= '0;
        else if (!served)
          flags_reg[i] <= '0;
        else
        begin
          flags_reg[i].offline <= fan_timeout_i[i];
          flags_reg[i].undervolt <=
            fan_status_i[i][`CAS_BIT_UNDERVOLT];
          flags_reg[i].calib <= fan_status_i[i][`CAS_BIT_CALIB];
          flags_reg[i].fault <= fan_status_i[i][`CAS_BIT_FAULT];
        end
      end
    end
  endgenerate
  assign flags_o = flags_reg;
endmodule

/* core/cas_pkg.sv */
// shared types of the cooler alarm supervisor
package cas_pkg;
  // software configuration, bit layout of the config register
  typedef struct packed {
    logic [3:0] fan_count;
    logic [2:0] spare;
    logic input_is_loop;
    logic [5:0] spare_src;
    logic [1:0] control_source;
  } cas_config_t;
  // alarms of one fan
  typedef struct packed {
    logic fault;
    logic calib;
    logic undervolt;
    logic offline;
  } cas_fan_flags_t;
  // unit-level alarms
  typedef struct packed {
    logic general;
    logic high_temp;
    logic low_current;
    logic sump_mid;
  } cas_unit_alarms_t;
  typedef enum logic {
    CAS_SUMP_NORMAL,
    CAS_SUMP_ALARM
  } cas_sump_state_t;
  // a fan index is served while it does not exceed the configured count
  function automatic logic cas_fan_in_range(input int idx,
                                            input logic [3:0] count);
    return idx < 32'(count) + 1;
  endfunction
endpackage

/* core/cas_qualifier.sv */
// seconds qualifier: condition held for a whole number of ticks
`timescale 1ns/1ps
`include "cas_regs.svh"
module cas_qualifier
  import cas_pkg::*;
#(
  parameter int SECONDS = 3
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic cond_i,
  output logic held_o
);
  localparam int CW = $clog2(SECONDS + 1);
  logic [CW-1:0] count_reg;
  generate
    if (SECONDS < 1)
    begin : g_bad
      $error("qualifier needs at least one second");
    end
  endgenerate
  // restart at zero as soon as the condition drops
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      count_reg <= '0;
    else if (!cond_i)
      count_reg <= '0;
    else if (tick_i && count_reg != CW'(SECONDS))
      count_reg <= count_reg + CW'(1);
  end
  assign held_o = cond_i && (count_reg == CW'(SECONDS));
endmodule

/* core/cas_regs.svh */
// register offsets, field positions, reset values and thresholds
`ifndef CAS_REGS_SVH
`define CAS_REGS_SVH
`define CAS_ADDR_W 6
`define CAS_OFF_CONFIG 6'h00
`define CAS_OFF_ALARMS 6'h04
`define CAS_OFF_FAN_OFFLINE 6'h08
`define CAS_OFF_FAN_UNDERVOLT 6'h0C
`define CAS_OFF_FAN_CALIB 6'h10
`define CAS_OFF_FAN_FAULT 6'h14
`define CAS_OFF_INPUTS 6'h18
`define CAS_OFF_LOOP_CURRENT 6'h1C
`define CAS_OFF_FLUID_TEMP 6'h20
`define CAS_CONFIG_RESET 16'h0000
`define CAS_SRC_CUSTOMER 2'h0
`define CAS_SRC_LEAVING_FLUID_TEMP 2'h1
`define CAS_CURRENT_LOW_UA 16'h0B_B8
`define CAS_TEMP_HIGH_DECI 16'sh03_52
`define CAS_TEMP_RELEASE_DECI 16'sh03_34
`define CAS_MID_LOST_SEC 60
`define CAS_MID_BACK_SEC 3
`define CAS_BIT_UNDERVOLT 13
`define CAS_BIT_CALIB 11
`define CAS_BIT_FAULT 9
`define CAS_MAX_FANS 15
`endif

/* core/cooler_alarm_supervisor.sv */
// cooler alarm supervisor: sump, loop current, fluid temp, fan alarms
//
// Behaviour
// - sump alarm on low, high, or mid lost 60s
// - sump alarm clears after mid true 3s, with low and high floats off
// - low current alarm: customer input, loop, <=3mA
// - low current releases above 3mA or config change
// - low current alarm forces emergency mode
// - high temp alarm: temp control, above 85.0C
// - high temp releases at 82C or config change
// - fan offline follows its polling timeout
// - only fans within configured count alarm
// - fans beyond count drop all alarms
// - fan undervoltage mirrors status high-byte bit 5
// - fan calibration error mirrors high-byte bit 3
// - fan fault mirrors high-byte bit 1
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "cas_regs.svh"
module cooler_alarm_supervisor
  import cas_pkg::*;
#(
  parameter int NUM_FANS = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [`CAS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // field inputs
  input wire logic sec_tick_i,
  input wire logic low_float_i,
  input wire logic mid_float_i,
  input wire logic high_float_i,
  input wire logic [15:0] loop_current_ua_i,
  input wire logic signed [15:0] leaving_fluid_temp_i,
  input wire logic [NUM_FANS-1:0] fan_timeout_i,
  input wire logic [NUM_FANS-1:0][15:0] fan_status_i,
  // outputs
  output logic general_alarm_o,
  output logic emergency_mode_o
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (NUM_FANS < 1 || NUM_FANS > `CAS_MAX_FANS)
    begin : g_bad_fans
      $error("NUM_FANS must lie between 1 and the fan count field limit");
    end
  endgenerate

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cas_config_t config_reg;
  cas_config_t config_next;
  cas_sump_state_t sump_state_reg;
  cas_sump_state_t sump_state_next;
  logic low_current_reg;
  logic low_current_next;
  logic high_temp_reg;
  logic high_temp_next;
  logic general_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic [31:0] read_value;
  logic request;
  logic write_now;
  logic mid_lost_held;
  logic mid_back_held;
  logic sump_trigger;
  logic on_customer;
  logic on_temp_ctrl;
  logic current_low;
  logic temp_over;
  logic temp_under;
  logic any_fan_alarm;
  cas_fan_flags_t [NUM_FANS-1:0] fan_flags;
  cas_unit_alarms_t unit_alarms;
  logic [NUM_FANS-1:0] offline_vec;
  logic [NUM_FANS-1:0] undervolt_vec;
  logic [NUM_FANS-1:0] calib_vec;
  logic [NUM_FANS-1:0] fault_vec;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // merge a write into a word under the byte enables
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        res[b*8 +: 8] = data[b*8 +: 8];
    end
    return res;
  endfunction

  // fan vectors widened to a bus word, upper bits zero
  function automatic logic [31:0] widen(input logic [NUM_FANS-1:0] v);
    logic [31:0] res;
    res = '0;
    res[NUM_FANS-1:0] = v;
    return res;
  endfunction

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle on every access
  // ----------------------------------------------------------------
  // the wait cycle lets read data come from a flop, not the decoder
  assign request = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = request && !ack_reg;
  assign write_now = avs_write_i && ack_reg;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= request && !ack_reg;
  end

  always_comb
  begin
    read_value = '0;
    case (avs_address_i)
      `CAS_OFF_CONFIG:
        read_value = 32'(config_reg);
      `CAS_OFF_ALARMS:
        read_value = 32'(unit_alarms);
      `CAS_OFF_FAN_OFFLINE:
        read_value = widen(offline_vec);
      `CAS_OFF_FAN_UNDERVOLT:
        read_value = widen(undervolt_vec);
      `CAS_OFF_FAN_CALIB:
        read_value = widen(calib_vec);
      `CAS_OFF_FAN_FAULT:
        read_value = widen(fault_vec);
      `CAS_OFF_INPUTS:
        read_value = {27'h000_0000, mid_back_held, mid_lost_held,
                      high_float_i, mid_float_i, low_float_i};
      `CAS_OFF_LOOP_CURRENT:
        read_value = {16'h0000, loop_current_ua_i};
      `CAS_OFF_FLUID_TEMP:
        read_value = {{16{leaving_fluid_temp_i[15]}}, leaving_fluid_temp_i};
      default:
        read_value = '0;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      readdata_reg <= '0;
    else if (avs_read_i && !ack_reg)
      readdata_reg <= read_value;
  end

  assign avs_readdata_o = readdata_reg;

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  // unused fields are forced to zero so they read back as zero
  always_comb
  begin
    config_next = config_reg;
    if (write_now && avs_address_i == `CAS_OFF_CONFIG)
    begin
      config_next = cas_config_t'(16'(merge_bytes(32'(config_reg),
                                                  avs_writedata_i,
                                                  avs_byteenable_i)));
      config_next.spare = '0;
      config_next.spare_src = '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      config_reg <= cas_config_t'(`CAS_CONFIG_RESET);
    else
      config_reg <= config_next;
  end

  // ----------------------------------------------------------------
  // sump mid-level alarm
  // ----------------------------------------------------------------
  cas_qualifier #(
    .SECONDS(`CAS_MID_LOST_SEC)
  ) u_mid_lost (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(sec_tick_i),
    .cond_i(!mid_float_i),
    .held_o(mid_lost_held)
  );

  cas_qualifier #(
    .SECONDS(`CAS_MID_BACK_SEC)
  ) u_mid_back (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(sec_tick_i),
    .cond_i(mid_float_i),
    .held_o(mid_back_held)
  );

  assign sump_trigger = low_float_i || high_float_i || mid_lost_held;

  // a standing trigger keeps the alarm even once the mid float is back
  always_comb
  begin
    sump_state_next = sump_state_reg;
    case (sump_state_reg)
      CAS_SUMP_NORMAL:
      begin
        if (sump_trigger)
          sump_state_next = CAS_SUMP_ALARM;
      end
      CAS_SUMP_ALARM:
      begin
        if (mid_back_held && !sump_trigger)
          sump_state_next = CAS_SUMP_NORMAL;
      end
      default:
        sump_state_next = CAS_SUMP_NORMAL;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sump_state_reg <= CAS_SUMP_NORMAL;
    else
      sump_state_reg <= sump_state_next;
  end

  // ----------------------------------------------------------------
  // low customer input current alarm
  // ----------------------------------------------------------------
  assign on_customer = config_reg.control_source == `CAS_SRC_CUSTOMER;
  assign current_low = loop_current_ua_i <= `CAS_CURRENT_LOW_UA;

  // set and release are exact complements, so this is a plain level
  always_comb
  begin
    low_current_next = low_current_reg;
    if (on_customer && config_reg.input_is_loop && current_low)
      low_current_next = 1'b1;
    else
      low_current_next = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      low_current_reg <= 1'b0;
    else
      low_current_reg <= low_current_next;
  end

  assign emergency_mode_o = low_current_reg;

  // ----------------------------------------------------------------
  // high leaving fluid temperature alarm
  // ----------------------------------------------------------------
  assign on_temp_ctrl =
    config_reg.control_source == `CAS_SRC_LEAVING_FLUID_TEMP;
  assign temp_over = leaving_fluid_temp_i > `CAS_TEMP_HIGH_DECI;
  assign temp_under = leaving_fluid_temp_i <= `CAS_TEMP_RELEASE_DECI;

  // between the two limits the alarm keeps its last value
  always_comb
  begin
    high_temp_next = high_temp_reg;
    if (!on_temp_ctrl)
      high_temp_next = 1'b0;
    else if (temp_over)
      high_temp_next = 1'b1;
    else if (temp_under)
      high_temp_next = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      high_temp_reg <= 1'b0;
    else
      high_temp_reg <= high_temp_next;
  end

  // ----------------------------------------------------------------
  // per-fan alarms
  // ----------------------------------------------------------------
  cas_fan_alarms #(
    .NUM_FANS(NUM_FANS)
  ) u_fans (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fan_count_i(config_reg.fan_count),
    .fan_timeout_i(fan_timeout_i),
    .fan_status_i(fan_status_i),
    .flags_o(fan_flags)
  );

  genvar f;
  generate
    for (f = 0; f < NUM_FANS; f++)
    begin : g_unpack
      assign offline_vec[f] = fan_flags[f].offline;
      assign undervolt_vec[f] = fan_flags[f].undervolt;
      assign calib_vec[f] = fan_flags[f].calib;
      assign fault_vec[f] = fan_flags[f].fault;
    end
  endgenerate

  assign any_fan_alarm = |{offline_vec, undervolt_vec, calib_vec, fault_vec};

  // ----------------------------------------------------------------
  // general alarm
  // ----------------------------------------------------------------
  // registered, so it trails the individual alarms by one cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      general_reg <= 1'b0;
    else
      general_reg <= (sump_state_reg == CAS_SUMP_ALARM) ||
                     low_current_reg || high_temp_reg ||
                     any_fan_alarm;
  end

  assign general_alarm_o = general_reg;

  always_comb
  begin
    unit_alarms.sump_mid = sump_state_reg == CAS_SUMP_ALARM;
    unit_alarms.low_current = low_current_reg;
    unit_alarms.high_temp = high_temp_reg;
    unit_alarms.general = general_reg;
  end

endmodule

/* sim/cas_chk.sv */
// port checker of the cooler alarm supervisor
`timescale 1ns/1ps
`include "cas_regs.svh"
module cas_chk
#(
  parameter int NUM_FANS = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`CAS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic low_float_i,
  input wire logic high_float_i,
  input wire logic [15:0] loop_current_ua_i,
  input wire logic signed [15:0] leaving_fluid_temp_i,
  input wire logic [NUM_FANS-1:0] fan_timeout_i,
  input wire logic [NUM_FANS-1:0][15:0] fan_status_i,
  input wire logic general_alarm_o,
  input wire logic emergency_mode_o
);
  // config shadow; byte lanes ignored, the bench writes whole words
  logic [15:0] cfg_reg;
  logic cur_low;
  logic temp_high;
  logic fan1_bad;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cfg_reg <= 16'h0000;
    else if (avs_write_i && !avs_waitrequest_o &&
             avs_address_i == `CAS_OFF_CONFIG)
      cfg_reg <= avs_writedata_i[15:0];
  end
  assign cur_low = cfg_reg[1:0] == `CAS_SRC_CUSTOMER && cfg_reg[8] &&
    loop_current_ua_i <= `CAS_CURRENT_LOW_UA;
  assign temp_high = cfg_reg[1:0] == `CAS_SRC_LEAVING_FLUID_TEMP &&
    leaving_fluid_temp_i > `CAS_TEMP_HIGH_DECI;
  assign fan1_bad = cfg_reg[15:12] != 4'h0 && (fan_timeout_i[0] ||
    (fan_status_i[0] & 16'h2A00) != 16'h0000);
  // ----------------
  // assertions
  // ----------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wait_one_a:
    assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) else $error("wait state too long");
  req_wait_a:
    assert property ($rose(avs_read_i) || $rose(avs_write_i)
      |-> avs_waitrequest_o) else $error("request taken with no wait");
  unmapped_read_a:
    assert property (avs_read_i && !avs_waitrequest_o &&
      avs_address_i > `CAS_OFF_FLUID_TEMP |-> avs_readdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
  sump_low_a:
    assert property (low_float_i |=> ##1 general_alarm_o)
      else $error("low float gave no alarm");
  sump_high_a:
    assert property (high_float_i |=> ##1 general_alarm_o)
      else $error("high float gave no alarm");
  cur_low_a:
    assert property (cur_low [*3] |-> emergency_mode_o)
      else $error("low current without emergency");
  cur_ok_a:
    assert property ((!cur_low) [*3] |-> !emergency_mode_o)
      else $error("emergency without low current");
  emerg_gen_a:
    assert property (emergency_mode_o [*2] |-> general_alarm_o)
      else $error("emergency without general alarm");
  temp_high_a:
    assert property (temp_high [*3] |-> general_alarm_o)
      else $error("high temperature without alarm");
  fan_one_a:
    assert property (fan1_bad [*3] |-> general_alarm_o)
      else $error("fan one fault without alarm");
  cover property (emergency_mode_o);
  cover property (temp_high && general_alarm_o);
  cover property (fan1_bad [*3]);
  cover property ($fell(general_alarm_o));
endmodule
bind cooler_alarm_supervisor cas_chk #(.NUM_FANS(NUM_FANS)) u_chk (.clk_i,
  .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_readdata_o, .avs_waitrequest_o, .low_float_i, .high_float_i,
  .loop_current_ua_i, .leaving_fluid_temp_i, .fan_timeout_i, .fan_status_i,
  .general_alarm_o, .emergency_mode_o);

/* sim/cas_field_model.sv */
// field side model: sump float switches and polled fan drives
`timescale 1ns/1ps
module cas_field_model
#(
  parameter int NUM_FANS = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] level_i,
  input wire logic [NUM_FANS-1:0] fan_on_i,
  input wire logic [NUM_FANS-1:0][15:0] fan_word_i,
  output logic low_float_o,
  output logic mid_float_o,
  output logic high_float_o,
  output logic [NUM_FANS-1:0] fan_timeout_o,
  output logic [NUM_FANS-1:0][15:0] fan_status_o
);
  // level 0 dry, 1 below mid, 2 normal, 3 overfull
  logic [NUM_FANS-1:0][15:0] last_reg;
  assign low_float_o = level_i == 2'h0;
  assign mid_float_o = level_i[1];
  assign high_float_o = level_i == 2'h3;
  // a silent fan leaves a stale word, shown inverted so nothing relies on it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fan_timeout_o <= '0;
      last_reg <= '0;
    end
    else
    begin
      fan_timeout_o <= ~fan_on_i;
      for (int i = 0; i < NUM_FANS; i++)
        if (fan_on_i[i])
          last_reg[i] <= fan_word_i[i];
    end
  end
  always_comb
    for (int i = 0; i < NUM_FANS; i++)
      fan_status_o[i] = fan_timeout_o[i] ? ~last_reg[i] : last_reg[i];
endmodule

/* sim/tb_cooler_alarm_supervisor.sv */
// self-checking bench of the cooler alarm supervisor
`timescale 1ns/1ps
`include "cas_regs.svh"
module tb_cooler_alarm_supervisor;
  localparam int NF = 8;
  localparam int LIMIT = 8000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic sec_tick_i = 1'b0;
  logic low_float_i, mid_float_i, high_float_i;
  logic [15:0] loop_current_ua_i = 16'h4E20;
  logic signed [15:0] leaving_fluid_temp_i = 16'sh00C8;
  logic [NF-1:0] fan_timeout_i;
  logic [NF-1:0][15:0] fan_status_i;
  logic general_alarm_o, emergency_mode_o;
  logic [1:0] level = 2'h2;
  logic [NF-1:0] fan_on = '1;
  logic [NF-1:0][15:0] fan_word = '0;
  logic [31:0] r, m;
  logic [3:0] n;
  logic e, ht, any;
  int tv [6] = '{851, 821, 820, 850, 851, 900};
  logic [3:0] nt [4] = '{4'h0, 4'h8, 4'hF, 4'h3};
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  cooler_alarm_supervisor #(.NUM_FANS(NF)) dut (.clk_i, .rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o,
    .sec_tick_i, .low_float_i, .mid_float_i, .high_float_i,
    .loop_current_ua_i, .leaving_fluid_temp_i, .fan_timeout_i,
    .fan_status_i, .general_alarm_o, .emergency_mode_o);
  cas_field_model #(.NUM_FANS(NF)) u_field (.clk_i, .rst_i, .level_i(level),
    .fan_on_i(fan_on), .fan_word_i(fan_word), .low_float_o(low_float_i),
    .mid_float_o(mid_float_i), .high_float_o(high_float_i),
    .fan_timeout_o(fan_timeout_i), .fan_status_o(fan_status_i));
  initial
    forever #12.5 clk_i = ~clk_i;
  // ----------------
  // helpers
  // ----------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do
      @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, r);
    check(r, exp);
  endtask
  task automatic alarms(input logic [3:0] x);
    rchk(`CAS_OFF_ALARMS, {28'h000_0000, x});
    // outputs looked at mid-cycle, away from the edge that launches them
    @(negedge clk_i);
    check(general_alarm_o, x[3]);
    check(emergency_mode_o, x[1]);
    @(posedge clk_i);
  endtask
  task automatic ticks(input int k);
    repeat (k)
    begin
      @(posedge clk_i);
      sec_tick_i <= 1'b1;
      @(posedge clk_i);
      sec_tick_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
  function automatic logic [31:0] cfg(input logic [3:0] c, input logic lp,
                                      input logic [1:0] s);
    return {16'h0000, c, 3'h0, lp, 6'h00, s};
  endfunction
  // high byte bits 5, 3, 1 of the status word sit at 13, 11, 9
  function automatic logic [31:0] fexp(input logic [3:0] c, input int j);
    logic [31:0] q;
    q = '0;
    for (int i = 0; i < NF; i++)
      if (i + 1 <= c)
        q[i] = j == 0 ? fan_timeout_i[i] : fan_status_i[i][15 - 2 * j];
    return q;
  endfunction
  // ----------------
  // main sequence
  // ----------------
  initial
  begin
    void'($urandom(13663));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(`CAS_OFF_CONFIG, 32'h0000_0000);
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF, r);
    rchk(6'h3C, 32'h0000_0000);
    bus(1'b1, `CAS_OFF_ALARMS, 32'h0000_000F, r);
    alarms(4'h0);
    for (int k = 0; k < 24; k++)
    begin
      loop_current_ua_i <= k < 8 ? 16'h0BB8 : k < 16 ? 16'h0BB9 :
        16'($urandom_range(0, 6000));
      bus(1'b1, `CAS_OFF_CONFIG, cfg(4'h0, k[2], k[1:0]), r);
      repeat (3) @(posedge clk_i);
      e = k[1:0] == 2'h0 && k[2] && loop_current_ua_i <= 16'h0BB8;
      alarms(e ? 4'hA : 4'h0);
    end
    bus(1'b1, `CAS_OFF_CONFIG, cfg(4'h0, 1'b0, 2'h1), r);
    ht = 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      leaving_fluid_temp_i <= k < 6 ? 16'(tv[k]) :
        16'($urandom_range(780, 900));
      repeat (3) @(posedge clk_i);
      ht = leaving_fluid_temp_i > 850 ? 1'b1 :
        leaving_fluid_temp_i <= 820 ? 1'b0 : ht;
      alarms(ht ? 4'hC : 4'h0);
    end
    leaving_fluid_temp_i <= 16'sh0384;
    repeat (3) @(posedge clk_i);
    alarms(4'hC);
    bus(1'b1, `CAS_OFF_CONFIG, cfg(4'h0, 1'b0, 2'h2), r);
    // alarm drops one edge after the config, the general alarm one later
    repeat (2) @(posedge clk_i);
    alarms(4'h0);
    leaving_fluid_temp_i <= 16'shFFCE;
    rchk(`CAS_OFF_FLUID_TEMP, 32'hFFFF_FFCE);
    rchk(`CAS_OFF_LOOP_CURRENT, {16'h0000, loop_current_ua_i});
    level <= 2'h1;
    ticks(59);
    alarms(4'h0);
    level <= 2'h2;
    ticks(1);
    level <= 2'h1;
    ticks(59);
    alarms(4'h0);
    ticks(1);
    alarms(4'h9);
    rchk(`CAS_OFF_INPUTS, 32'h0000_0008);
    level <= 2'h2;
    ticks(2);
    level <= 2'h1;
    @(posedge clk_i);
    level <= 2'h2;
    ticks(2);
    alarms(4'h9);
    ticks(1);
    alarms(4'h0);
    level <= 2'h0;
    repeat (2) @(posedge clk_i);
    alarms(4'h9);
    level <= 2'h2;
    ticks(3);
    alarms(4'h0);
    level <= 2'h3;
    ticks(4);
    alarms(4'h9);
    level <= 2'h2;
    ticks(3);
    alarms(4'h0);
    for (int k = 0; k < 40; k++)
    begin
      n = k < 4 ? nt[k] : 4'($urandom_range(0, 15));
      fan_on <= NF'($urandom);
      for (int i = 0; i < NF; i++)
        fan_word[i] <= 16'($urandom);
      bus(1'b1, `CAS_OFF_CONFIG, cfg(n, 1'b0, 2'h2), r);
      repeat (3) @(posedge clk_i);
      any = 1'b0;
      for (int j = 0; j < 4; j++)
      begin
        m = fexp(n, j);
        any = any | (m != 0);
        rchk(6'(8 + 4 * j), m);
      end
      @(negedge clk_i);
      check(general_alarm_o, any);
      @(posedge clk_i);
    end
    finish_test();
  end
endmodule
